// *** core/serial_port_buffered_regs.sv ***
// Purpose: Serial control port with double-buffered register bank
// Assumes: Serial clock well below a sixth of clock_i
// Notes:   Pins pass three flops, clock, select and boot enable a fourth filter flop; script has priority over serial writes
`timescale 1ns/1ns
module serial_port_buffered_regs
  import serial_port_pkg::*;
#(
  parameter int BUF_N = 4
) (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  reset_n_i,
  // Serial pins
  input  wire logic                  sclk_i,
  input  wire logic                  csb_n_i,
  input  wire logic                  sdio_i,
  output logic                       sdio_o,
  output logic                       sdio_oe_o,
  output logic                       sdo_o,
  output logic                       sdo_oe_o,
  // Device side
  input  wire logic                  boot_en_i,
  input  wire logic [7:0]            status_i,
  output logic [BUF_N-1:0][7:0]      active_o,
  output logic                       pll_cal_o,
  output logic                       boot_busy_o
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic       sclk_rise, sclk_fall, cs_act, din;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // All stages start at idle levels, so no false select or edge after reset
      s1_reg   <= PIN_IDLE;
      s2_reg   <= PIN_IDLE;
      s3_reg   <= PIN_IDLE;
      filt_reg <= PIN_IDLE;
    end else begin
      s1_reg <= {boot_en_i, sdio_i, csb_n_i, sclk_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < 4; i++) begin
        if (s2_reg[i] == s3_reg[i]) filt_reg[i] <= s3_reg[i];
      end
    end
  end

  // Edges only once two stages agree, to reject a single glitch
  assign sclk_rise = (s2_reg[0] == s3_reg[0]) && s3_reg[0] && !filt_reg[0];
  assign sclk_fall = (s2_reg[0] == s3_reg[0]) && !s3_reg[0] && filt_reg[0];
  assign cs_act    = !filt_reg[1];
  assign din       = s3_reg[2];

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic                   sdo_en_reg, lsb_reg, rb_sel_reg, update_reg, soft_rst_reg;
  logic [BUF_N-1:0][7:0]  buf_reg, act_reg;
  logic [7:0]             status_snap_reg;
  script_state_type       scr_state_reg;
  logic [SCRIPT_AW-1:0]   ptr_reg;
  logic [7:0]             cnt_reg, rom_byte;
  logic [ADDR_W-1:0]      saddr_reg;
  logic                   scr_we, scr_commit;

  function automatic logic in_buf(input logic [ADDR_W-1:0] a);
    in_buf = (a >= BUF_BASE) && (a < BUF_BASE + ADDR_W'(BUF_N));
  endfunction : in_buf

  function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = a - BUF_BASE;
    read_byte = 8'h00;
    if (a == CFG_ADDR) read_byte = {sdo_en_reg, lsb_reg, 6'h00};
    else if (a == RB_ADDR) read_byte = {7'h00, rb_sel_reg};
    else if (a == UPD_ADDR) read_byte = {7'h00, update_reg};      // [RL10]
    else if (a == STATUS_ADDR) read_byte = status_snap_reg;
    else if (in_buf(a)) begin
      read_byte = rb_sel_reg ? buf_reg[idx] : act_reg[idx];      // [RL6]
    end
  endfunction : read_byte

  // ------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------
  logic [15:0]        sh_reg, sh_next;
  logic [3:0]         bit_cnt_reg;
  logic               instr_reg, rd_reg, byte_end, spi_we;
  logic [7:0]         tx_reg, rx_byte;
  logic [ADDR_W-1:0]  addr_reg, addr_step, instr_addr;

  assign sh_next    = lsb_reg ? {din, sh_reg[15:1]} : {sh_reg[14:0], din};     // [RL2] [RL3]
  assign rx_byte    = lsb_reg ? sh_next[15:8] : sh_next[7:0];
  assign instr_addr = sh_next[ADDR_W-1:0];
  assign byte_end   = cs_act && sclk_rise && !instr_reg && (bit_cnt_reg == BYTE_LAST);
  assign spi_we     = byte_end && !rd_reg;
  assign addr_step  = lsb_reg ? addr_reg + 13'h0001 : addr_reg - 13'h0001;  // [RL2] [RL3]

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sh_reg      <= 16'h0000;
      bit_cnt_reg <= 4'h0;
      instr_reg   <= 1'b1;
      rd_reg      <= 1'b0;
      addr_reg    <= CFG_ADDR;
    end else if (!cs_act) begin
      bit_cnt_reg <= 4'h0;
      instr_reg   <= 1'b1;
      rd_reg      <= 1'b0;
    end else if (sclk_rise) begin
      sh_reg      <= sh_next;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (instr_reg && bit_cnt_reg == INSTR_LAST) begin
        instr_reg   <= 1'b0;
        bit_cnt_reg <= 4'h0;
        rd_reg      <= sh_next[RD_BIT];
        addr_reg    <= instr_addr;
      end else if (byte_end) begin
        bit_cnt_reg <= 4'h0;
        addr_reg    <= addr_step;
      end
    end
  end

  // Read byte is fetched at the frame point, shifted out on falling edges
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_reg    <= BYTE_RESET;
      sdio_o    <= BIT_RESET;
      sdo_o     <= BIT_RESET;
      sdio_oe_o <= BIT_RESET;
      sdo_oe_o  <= BIT_RESET;
    end else begin
      sdo_oe_o  <= cs_act && rd_reg && !instr_reg && sdo_en_reg;    // [RL1]
      sdio_oe_o <= cs_act && rd_reg && !instr_reg && !sdo_en_reg;   // [RL1]
      if (cs_act && sclk_rise && instr_reg && bit_cnt_reg == INSTR_LAST) begin
        tx_reg <= read_byte(instr_addr);
      end else if (byte_end) begin
        tx_reg <= read_byte(addr_step);
      end else if (cs_act && sclk_fall && rd_reg && !instr_reg) begin
        sdio_o <= lsb_reg ? tx_reg[0] : tx_reg[7];
        sdo_o  <= lsb_reg ? tx_reg[0] : tx_reg[7];
        tx_reg <= lsb_reg ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              wr_spi;

  assign wr_spi  = spi_we && !scr_we;
  assign wr_addr = scr_we ? saddr_reg : addr_reg;
  assign wr_data = scr_we ? rom_byte : rx_byte;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sdo_en_reg   <= BIT_RESET;
      lsb_reg      <= BIT_RESET;
      rb_sel_reg   <= BIT_RESET;
      soft_rst_reg <= BIT_RESET;
      update_reg   <= BIT_RESET;
    end else if (soft_rst_reg) begin
      sdo_en_reg   <= BIT_RESET;                                     // [RL4]
      lsb_reg      <= BIT_RESET;
      rb_sel_reg   <= BIT_RESET;
      soft_rst_reg <= BIT_RESET;
      update_reg   <= BIT_RESET;
    end else begin
      soft_rst_reg <= wr_spi && addr_reg == CFG_ADDR && rx_byte[CFG_RST_BIT];  // [RL4]
      update_reg   <= scr_commit ||
                      (wr_spi && addr_reg == UPD_ADDR && rx_byte[UPD_BIT]);   // [RL10] [RL13]
      // Address zero is only reachable from the serial port
      if (wr_spi && addr_reg == CFG_ADDR) begin                    // [RL5]
        sdo_en_reg <= rx_byte[CFG_SDO_BIT];                          // [RL1]
        lsb_reg    <= rx_byte[CFG_LSB_BIT];
      end
      if ((wr_spi || scr_we) && wr_addr == RB_ADDR) rb_sel_reg <= wr_data[RB_SEL_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buf_reg         <= '0;
      act_reg         <= '0;
      status_snap_reg <= BYTE_RESET;
    end else if (soft_rst_reg) begin
      buf_reg         <= '0;
      act_reg         <= '0;
      status_snap_reg <= BYTE_RESET;
    end else begin
      if ((wr_spi || scr_we) && in_buf(wr_addr)) begin
        buf_reg[wr_addr - BUF_BASE] <= wr_data;                    // [RL8]
      end
      if (update_reg) begin
        act_reg         <= buf_reg;                                  // [RL7] [RL8]
        status_snap_reg <= status_i;                                 // [RL9]
      end
    end
  end

  assign active_o = act_reg;

  // ------------------------------------------------------------
  // Load script interpreter
  // ------------------------------------------------------------
  assign rom_byte   = SCRIPT_IMAGE[ptr_reg];
  assign scr_we     = scr_state_reg == S_DATA;
  assign scr_commit = scr_state_reg == S_OP && rom_byte == OP_UPDATE;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scr_state_reg <= S_IDLE;
      ptr_reg       <= '0;
      cnt_reg       <= BYTE_RESET;
      saddr_reg     <= CFG_ADDR;
      pll_cal_o     <= BIT_RESET;
      boot_busy_o   <= BIT_RESET;
    end else begin
      pll_cal_o   <= scr_state_reg == S_OP && rom_byte == OP_CAL;   // [RL12]
      boot_busy_o <= scr_state_reg != S_IDLE;
      unique case (scr_state_reg)
        S_IDLE: begin
          ptr_reg <= '0;
          if (soft_rst_reg && filt_reg[3]) scr_state_reg <= S_OP;     // [RL4]
        end
        S_OP: begin
          ptr_reg <= ptr_reg + 1'b1;
          if (rom_byte == OP_END) begin
            scr_state_reg <= S_IDLE;                                 // [RL14]
          end else if (!rom_byte[7]) begin
            cnt_reg       <= rom_byte;                               // [RL11]
            scr_state_reg <= S_HI;
          end
        end
        S_HI: begin
          saddr_reg[12:8] <= rom_byte[4:0];                          // [RL11]
          ptr_reg         <= ptr_reg + 1'b1;
          scr_state_reg   <= S_LO;
        end
        S_LO: begin
          saddr_reg[7:0] <= rom_byte;
          ptr_reg        <= ptr_reg + 1'b1;
          scr_state_reg  <= S_DATA;
        end
        S_DATA: begin
          saddr_reg <= saddr_reg + 13'h0001;
          ptr_reg   <= ptr_reg + 1'b1;
          cnt_reg   <= cnt_reg - 8'h01;
          if (cnt_reg == BYTE_RESET) scr_state_reg <= S_OP;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_upd_clear;
    @(posedge clock_i) disable iff (!reset_n_i)
    update_reg && !scr_commit && !wr_spi |=> !update_reg;
  endproperty
  a_upd_clear: assert property (p_upd_clear) // [RL10]
    else $error("update strobe did not clear");

  property p_commit;
    @(posedge clock_i) disable iff (!reset_n_i)
    update_reg && !soft_rst_reg |=> act_reg == $past(buf_reg);
  endproperty
  a_commit: assert property (p_commit) // [RL7]
    else $error("active copy differs from buffer after update");

  property p_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
    !update_reg && !soft_rst_reg |=> $stable(act_reg);
  endproperty
  a_hold: assert property (p_hold) // [RL8]
    else $error("active copy changed without update");

  property p_status;
    @(posedge clock_i) disable iff (!reset_n_i)
    !update_reg && !soft_rst_reg |=> $stable(status_snap_reg);
  endproperty
  a_status: assert property (p_status) // [RL9]
    else $error("status snapshot moved without update");

  property p_soft;
    @(posedge clock_i) disable iff (!reset_n_i)
    soft_rst_reg && filt_reg[3] && scr_state_reg == S_IDLE
      |=> scr_state_reg == S_OP && !sdo_en_reg && !lsb_reg;
  endproperty
  a_soft: assert property (p_soft) // [RL4]
    else $error("soft reset did not start download");

  property p_cal;
    @(posedge clock_i) disable iff (!reset_n_i)
    pll_cal_o |-> $past(scr_state_reg) == S_OP && $past(rom_byte) == OP_CAL;
  endproperty
  a_cal: assert property (p_cal) // [RL12]
    else $error("calibrate pulse without its script byte");

  property p_end;
    @(posedge clock_i) disable iff (!reset_n_i)
    scr_state_reg == S_OP && rom_byte == OP_END |=> scr_state_reg == S_IDLE ##1
      (scr_state_reg == S_IDLE || $past(soft_rst_reg));
  endproperty
  a_end: assert property (p_end) // [RL14]
    else $error("script kept running after end byte");

  property p_cfg_excl;
    @(posedge clock_i) disable iff (!reset_n_i)
    scr_we && !soft_rst_reg |=> $stable(sdo_en_reg) && $stable(lsb_reg);
  endproperty
  a_cfg_excl: assert property (p_cfg_excl) // [RL5]
    else $error("script altered serial configuration");

  property p_pin;
    @(posedge clock_i) disable iff (!reset_n_i)
    sdo_oe_o |-> $past(sdo_en_reg) && !sdio_oe_o;
  endproperty
  a_pin: assert property (p_pin) // [RL1]
    else $error("read data on wrong pin");

  property p_step;
    @(posedge clock_i) disable iff (!reset_n_i)
    byte_end |=> addr_reg == ($past(lsb_reg) ? $past(addr_reg) + 13'h0001
                                            : $past(addr_reg) - 13'h0001);
  endproperty
  a_step: assert property (p_step) // [RL2] [RL3]
    else $error("address step in wrong direction");

  c_write: cover property (@(posedge clock_i) spi_we && in_buf(addr_reg));
  c_commit: cover property (@(posedge clock_i) update_reg ##1 act_reg != '0);
  c_script: cover property (@(posedge clock_i) scr_state_reg == S_DATA ##[1:20] pll_cal_o);
  c_read4w: cover property (@(posedge clock_i) sdo_oe_o && lsb_reg);

endmodule : serial_port_buffered_regs

// *** pkg/serial_port_pkg.sv ***
// Purpose: Constants for the serial port register bank and its load script
// Assumes: 13-bit register space, 20 MHz system clock
// Notes:   Script image stands in for the non-volatile store
// Summary of operation
// RL1: Config bit 7 set sends read data on the separate output pin, else 3-wire.
// RL2: Config bit 6 set shifts LSB and byte first; address steps upward.
// RL3: Config bit 6 clear shifts MSB and byte first; address steps downward.
// RL4: Config bit 5 resets the device and starts the script download if enabled.
// RL5: Config register at address zero is never taken from the store.
// RL6: Readback bit 0 selects buffered values, else active values are read.
// RL7: Writing 1 to update bit 0 copies buffered registers into active ones.
// RL8: Buffered registers act only after the update strobe; live ones act at once.
// RL9: Status register snapshot refreshes only on the update strobe.
// RL10: Update strobe bit clears itself and reads back as 0.
// RL11: Script data entry is a count byte then a two-byte start address.
// RL12: Script byte A0 pulses output PLL calibration, then continues.
// RL13: Script byte 80 acts as update strobe for what was loaded so far.
// RL14: Script byte FF stops the interpreter; later entries are unused.
package serial_port_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int         ADDR_W      = 13;
  localparam logic [12:0] CFG_ADDR    = 13'h0000;
  localparam logic [12:0] RB_ADDR     = 13'h0004;
  localparam logic [12:0] UPD_ADDR    = 13'h0005;
  localparam logic [12:0] STATUS_ADDR = 13'h0D00;
  localparam logic [12:0] BUF_BASE    = 13'h0600;
  localparam int         CFG_SDO_BIT = 7;
  localparam int         CFG_LSB_BIT = 6;
  localparam int         CFG_RST_BIT = 5;
  localparam int         RB_SEL_BIT  = 0;
  localparam int         UPD_BIT     = 0;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic       BIT_RESET   = 1'b0;
  // Idle pin levels {boot enable, data, chip select, serial clock}
  localparam logic [3:0] PIN_IDLE    = 4'h2;

  // ------------------------------------------------------------
  // Serial framing
  // ------------------------------------------------------------
  localparam logic [3:0] INSTR_LAST  = 4'hF;
  localparam logic [3:0] BYTE_LAST   = 4'h7;
  localparam int         RD_BIT      = 15;

  // ------------------------------------------------------------
  // Load script
  // ------------------------------------------------------------
  localparam logic [7:0] OP_UPDATE   = 8'h80;
  localparam logic [7:0] OP_CAL      = 8'hA0;
  localparam logic [7:0] OP_END      = 8'hFF;
  localparam int         SCRIPT_AW   = 4;
  localparam logic [7:0] SCRIPT_IMAGE [0:15] = '{
    8'h03, 8'h06, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'hA0,
    8'h80, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_OP   = 5'b00010,
    S_HI   = 5'b00100,
    S_LO   = 5'b01000,
    S_DATA = 5'b10000
  } script_state_type;

endpackage : serial_port_pkg

// *** testbench/spi_host_model.sv ***
// Purpose: Host serial controller model for the register bank
// Assumes: Six system clocks per serial clock half period
// Notes:   Serial clock stands still low between frames
`timescale 1ns/1ns
module spi_host_model (
  // Clock
  input  wire logic clock_i,
  // Lines from the device
  input  wire logic sdio_wire_i,
  input  wire logic sdo_i,
  // Lines to the device
  output logic      sclk_o,
  output logic      csb_n_o,
  output logic      sdio_o,
  output logic      sdio_oe_o
);
  // ------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------
  // Device syncs pins through flops, so each half period is slow
  localparam int HALF = 6;

  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #5;
  endtask : step

  // Data set in low phase, taken by the device on the rise
  task automatic shift_bit(input logic b, input logic drv, input logic four, output logic r);
    sdio_o = b;
    sdio_oe_o = drv;
    step(HALF);
    r = four ? sdo_i : sdio_wire_i;
    sclk_o = 1'b1;
    step(HALF);
    sclk_o = 1'b0;
  endtask : shift_bit

  task automatic frame(input logic lsb, input logic four, input logic rd,
                       input logic [12:0] addr, input int n,
                       input logic [31:0] wdata, output logic [31:0] rdata);
    logic [15:0] instr;
    logic        r;
    instr = {rd, 2'b00, addr};
    rdata = '0;
    csb_n_o = 1'b0;
    for (int j = 0; j < 16; j++) begin
      shift_bit(instr[lsb ? j : 15 - j], 1'b1, four, r);
    end
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        shift_bit(wdata[8 * k + (lsb ? i : 7 - i)], !rd, four, r);
        rdata[8 * k + (lsb ? i : 7 - i)] = r;
      end
    end
    step(HALF);
    csb_n_o = 1'b1;
    sdio_oe_o = 1'b0;
    step(HALF);
  endtask : frame
endmodule : spi_host_model

// *** testbench/test_serial_port_buffered_regs.sv ***
// Purpose: Self-checking bench for the buffered serial register bank
// Assumes: Host model owns the serial pins; status driven directly
// Notes:   Boot image contents come from the package
`timescale 1ns/1ns
module test_serial_port_buffered_regs;
  import serial_port_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic            clock_i = 1'b0;
  logic            reset_n_i = 1'b0;
  logic            sclk, csb_n, h_d, h_oe, dut_d, dut_oe, sdo, sdo_oe;
  logic            wire_d, sdo_line, pll_cal, boot_busy;
  logic            boot_en = 1'b0;
  logic            idle_pat = 1'b0;
  logic            lsb = 1'b0;
  logic            four = 1'b0;
  logic            seen_sdio_oe = 1'b0;
  logic            seen_sdo_oe = 1'b0;
  logic            seen_busy = 1'b0;
  logic [7:0]      status = 8'h00;
  logic [3:0][7:0] active;
  logic [31:0]     rdata;
  int              errors = 0;
  int              n_checks = 0;
  int              n_cal = 0;

  always #25 clock_i = ~clock_i;
  // Released line toggles so a stale bit never reads as valid
  always @(posedge clock_i) idle_pat <= ~idle_pat;
  assign wire_d = dut_oe ? dut_d : (h_oe ? h_d : idle_pat);
  // Undriven output pin shows the inverse of its last bit
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  always @(posedge clock_i) begin
    seen_sdio_oe <= seen_sdio_oe | dut_oe;
    seen_sdo_oe <= seen_sdo_oe | sdo_oe;
    seen_busy <= seen_busy | boot_busy;
    if (pll_cal === 1'b1) n_cal <= n_cal + 1;
  end

  serial_port_buffered_regs #(.BUF_N(4)) DUT (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .csb_n_i(csb_n),
    .sdio_i(wire_d), .sdio_o(dut_d), .sdio_oe_o(dut_oe), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .boot_en_i(boot_en), .status_i(status), .active_o(active), .pll_cal_o(pll_cal),
    .boot_busy_o(boot_busy));

  spi_host_model host (
    .clock_i(clock_i), .sdio_wire_i(wire_d), .sdo_i(sdo_line), .sclk_o(sclk),
    .csb_n_o(csb_n), .sdio_o(h_d), .sdio_oe_o(h_oe));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [12:0] a, input int n, input logic [31:0] d);
    host.frame(lsb, four, 1'b0, a, n, d, rdata);
  endtask : wr

  task automatic rd(input logic [12:0] a, input int n);
    host.frame(lsb, four, 1'b1, a, n, 32'h0, rdata);
  endtask : rd

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    #5;
    reset_n_i = 1'b1;
    repeat (8) @(posedge clock_i);
    #5;
    rd(CFG_ADDR, 1);
    check("config", rdata, 32'h0);
    rd(RB_ADDR, 1);
    check("readback_sel", rdata, 32'h0);
    rd(UPD_ADDR, 1);
    check("strobe", rdata, 32'h0);
    check("sdio_oe seen", seen_sdio_oe, 32'h1);
    check("sdo_oe seen", seen_sdo_oe, 32'h0);
    // Downward multibyte write lands at 0603..0600
    wr(BUF_BASE + 13'h3, 4, 32'hD4C3B2A1);
    check("active", active, 32'h0);
    wr(RB_ADDR, 1, 32'h01);
    rd(BUF_BASE + 13'h3, 4);
    check("buffer read", rdata, 32'hD4C3B2A1);
    wr(RB_ADDR, 1, 32'h00);
    rd(BUF_BASE, 1);
    check("active read", rdata, 32'h0);
    status = 8'h5A;
    wr(UPD_ADDR, 1, 32'h01);
    check("active", active, 32'hA1B2C3D4);
    rd(UPD_ADDR, 1);
    check("strobe", rdata, 32'h0);
    status = 8'h3C;
    rd(STATUS_ADDR, 1);
    check("status", rdata, 32'h5A);
    wr(UPD_ADDR, 1, 32'h01);
    rd(STATUS_ADDR, 1);
    check("status", rdata, 32'h3C);
    // LSB first and 4-wire from the next frame on
    wr(CFG_ADDR, 1, 32'hC0);
    lsb = 1'b1;
    four = 1'b1;
    wr(BUF_BASE, 4, 32'h04030201);
    wr(RB_ADDR, 1, 32'h01);
    seen_sdio_oe = 1'b0;
    seen_sdo_oe = 1'b0;
    rd(BUF_BASE, 4);
    check("lsb buffer read", rdata, 32'h04030201);
    check("sdo_oe seen", seen_sdo_oe, 32'h1);
    check("sdio_oe seen", seen_sdio_oe, 32'h0);
    rd(CFG_ADDR, 1);
    check("config", rdata, 32'hC0);
    rd(13'h0003, 1);
    check("unmapped", rdata, 32'h0);
    wr(UPD_ADDR, 1, 32'h01);
    check("active", active, 32'h04030201);
    // Soft reset, first without then with the boot image
    for (int b = 0; b < 2; b++) begin
      boot_en = b[0];
      n_cal = 0;
      seen_busy = 1'b0;
      wr(CFG_ADDR, 1, 32'h20);
      lsb = 1'b0;
      four = 1'b0;
      for (int t = 0; t < 100 && boot_busy !== 1'b0; t++) @(posedge clock_i);
      #5;
      if (boot_busy !== 1'b0) begin
        errors++;
        complete_run();
      end
      check("boot seen", seen_busy, b);
      check("cal pulses", n_cal, b);
      check("active", active, b ? 32'h44332211 : 32'h0);
      rd(CFG_ADDR, 1);
      check("config", rdata, 32'h0);
    end
    complete_run();
  end
endmodule : test_serial_port_buffered_regs
